/* verilog/wdcm_params.svh */
// constants of the watchdog and clock monitor block
`ifndef WDCM_PARAMS_SVH
`define WDCM_PARAMS_SVH

`define WDCM_CLK_MHZ      125
`define WDCM_BUS_DIV      4
`define WDCM_TO0_US       8192
`define WDCM_TO1_US       32768
`define WDCM_TO2_US       131070
`define WDCM_TO3_US       524500
`define WDCM_SEL_WINDOW   7'h40
`define WDCM_RST_MCYC     3
`define WDCM_CM_LIMIT_US  50

`define WDCM_SVC_ARM      8'h55
`define WDCM_SVC_FIRE     8'hAA

`define WDCM_OFS_SERVICE  8'h00
`define WDCM_OFS_OPTION   8'h04
`define WDCM_OFS_CONFIG   8'h08
`define WDCM_OFS_CAUSE    8'h0C
`define WDCM_OFS_STATUS   8'h10
`define WDCM_OFS_CLEAR    8'h14
`define WDCM_OFS_ENABLE   8'h18

`define WDCM_OPT_TSEL_LSB 0
`define WDCM_OPT_CCEN_BIT 2
`define WDCM_OPT_LOCK_BIT 3
`define WDCM_CFG_DIS_BIT  0
`define WDCM_CAU_WIN_BIT  2

`define WDCM_EV_WD        0
`define WDCM_EV_CM        1
`define WDCM_EV_BAD       2
`define WDCM_EV_W         3

`define WDCM_TSEL_RST     2'h0
`define WDCM_NV_FACTORY   1'h1

`endif

/* verilog/wdcm_pkg.sv */
// types shared by the watchdog and clock monitor block
package wdcm_pkg;
  typedef enum logic [1:0] {
    WDCM_CAUSE_EXT,
    WDCM_CAUSE_WD,
    WDCM_CAUSE_CM
  } wdcm_cause_type;

  typedef enum logic {
    WDCM_RS_IDLE,
    WDCM_RS_PULSE
  } wdcm_rst_state_type;
endpackage

/* verilog/wdcm_nv_cell.sv */
// nonvolatile storage cell for the watchdog disable bit
`timescale 1ns/100ps
`default_nettype none
`include "wdcm_params.svh"
module wdcm_nv_cell #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,   // block clock
  input  wire logic             we_i,    // write strobe
  input  wire logic [WIDTH-1:0] wdata_i, // value to store
  output logic      [WIDTH-1:0] rdata_o  // stored value, registered
);
  // power-up content stands for the factory state; rst_i never touches it
  logic [WIDTH-1:0] cell_r  = WIDTH'(`WDCM_NV_FACTORY);
  logic [WIDTH-1:0] rdata_r = WIDTH'(`WDCM_NV_FACTORY);

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      cell_r <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_r <= we_i ? wdata_i : cell_r;
  end

  assign rdata_o = rdata_r;
endmodule // wdcm_nv_cell
`default_nettype wire

/* verilog/wdcm_clk_monitor.sv */
// bus clock divider and slow or stopped clock detector
`timescale 1ns/100ps
`default_nettype none
`include "wdcm_params.svh"
module wdcm_clk_monitor #(
  parameter int unsigned LIMIT_CYC = `WDCM_CM_LIMIT_US * `WDCM_CLK_MHZ
) (
  input  wire logic clk_i,        // block clock
  input  wire logic rst_i,        // reset, sync, high
  input  wire logic osc_tick_i,   // one crystal cycle
  input  wire logic stop_clocks_i,// stop-all-clocks mode
  input  wire logic enable_i,     // monitor armed
  output logic      bus_tick_o,   // one bus clock cycle
  output logic      fail_o        // clock failure pulse
);
  logic [1:0]  div_r;
  logic        tick_r;
  logic [15:0] gap_r;
  logic        fail_r;

  // bus clock is a quarter of the crystal; stop mode freezes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r  <= 2'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= osc_tick_i & ~stop_clocks_i & (div_r == 2'h3);
      if (osc_tick_i & ~stop_clocks_i) begin
        div_r <= div_r + 2'h1;
      end
    end
  end

  // limit sits between the 200 kHz and 10 kHz bus periods
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_r || !enable_i) begin
      gap_r  <= 16'h0000;
      fail_r <= 1'b0;
    end else begin
      fail_r <= (gap_r == 16'(LIMIT_CYC - 1));
      if (gap_r != 16'(LIMIT_CYC)) begin
        gap_r <= gap_r + 16'h0001;
      end
    end
  end

  assign bus_tick_o = tick_r;
  assign fail_o     = fail_r;

  a_gap_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_r |=> gap_r == 16'h0000) else $error("gap not restarted by bus tick");
endmodule // wdcm_clk_monitor
`default_nettype wire

/* verilog/wdcm_top.sv */
// watchdog timer and clock monitor with avalon register slave
`timescale 1ns/100ps
`default_nettype none
`include "wdcm_params.svh"
module wdcm_top #(
  parameter int unsigned TO0_TICKS   = (`WDCM_TO0_US * `WDCM_CLK_MHZ) / `WDCM_BUS_DIV,
  parameter int unsigned TO1_TICKS   = (`WDCM_TO1_US * `WDCM_CLK_MHZ) / `WDCM_BUS_DIV,
  parameter int unsigned TO2_TICKS   = (`WDCM_TO2_US * `WDCM_CLK_MHZ) / `WDCM_BUS_DIV,
  parameter int unsigned TO3_TICKS   = (`WDCM_TO3_US * `WDCM_CLK_MHZ) / `WDCM_BUS_DIV,
  parameter int unsigned CM_LIMIT_CYC = `WDCM_CM_LIMIT_US * `WDCM_CLK_MHZ
) (
  input  wire logic                    clk_i,             // crystal-rate clock
  input  wire logic                    rst_i,             // reset, sync, high
  input  wire logic [7:0]              avs_address_i,     // byte address
  input  wire logic                    avs_read_i,        // read request
  input  wire logic                    avs_write_i,       // write request
  input  wire logic [31:0]             avs_writedata_i,   // write data
  input  wire logic [3:0]              avs_byteenable_i,  // byte lanes
  output logic      [31:0]             avs_readdata_o,    // read data
  output logic                         avs_waitrequest_o, // stall
  input  wire logic                    osc_tick_i,        // crystal running
  input  wire logic                    stop_clocks_i,     // stop mode
  output logic                         reset_line_o,      // reset pin value
  output logic                         reset_line_oe_o,   // reset pin drive
  output wdcm_pkg::wdcm_cause_type     vector_sel_o,      // reset vector
  output logic                         irq_o              // interrupt
);
  import wdcm_pkg::*;

  localparam int RST_CYC = `WDCM_RST_MCYC * `WDCM_BUS_DIV;

  wdcm_rst_state_type rst_state_r;
  logic [3:0]   pulse_cnt_r;
  logic         int_rst;
  logic         ack_r;
  logic [31:0]  rdata_r;
  logic         wr_go;
  logic         be0;
  logic [7:0]   wbyte;
  logic         bus_tick;
  logic         cm_fail;
  logic [6:0]   win_cnt_r;
  logic         win_open;
  logic [1:0]   tsel_r;
  logic         cc_en_r;
  logic         cc_lock_r;
  logic         cm_on;
  logic         nv_dis;
  logic         armed_r;
  logic         svc_wr;
  logic         svc_done;
  logic         bad_svc;
  logic [23:0]  wd_cnt_r;
  logic [23:0]  wd_limit;
  logic         wd_en;
  logic         wd_fail;
  logic         fail;
  wdcm_cause_type cause_r;
  logic [`WDCM_EV_W-1:0] ev;
  logic [`WDCM_EV_W-1:0] status_r;
  logic [`WDCM_EV_W-1:0] irq_en_r;
  logic         irq_r;

  assign int_rst = rst_i | (rst_state_r == WDCM_RS_PULSE);

  // one wait state on every access keeps read data registered
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign wr_go = avs_write_i & ack_r;
  assign be0   = avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_i && !ack_r) begin
      rdata_r <= 32'h0000_0000;
      case (avs_address_i)
        `WDCM_OFS_OPTION: begin
          rdata_r[`WDCM_OPT_TSEL_LSB +: 2] <= tsel_r;
          rdata_r[`WDCM_OPT_CCEN_BIT]      <= cc_en_r;
          rdata_r[`WDCM_OPT_LOCK_BIT]      <= cc_lock_r;
        end
        `WDCM_OFS_CONFIG: rdata_r[`WDCM_CFG_DIS_BIT] <= nv_dis;
        `WDCM_OFS_CAUSE: begin
          rdata_r[1:0]              <= cause_r;
          rdata_r[`WDCM_CAU_WIN_BIT] <= win_open;
        end
        `WDCM_OFS_STATUS: rdata_r[`WDCM_EV_W-1:0] <= status_r;
        `WDCM_OFS_ENABLE: rdata_r[`WDCM_EV_W-1:0] <= irq_en_r;
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata_o = rdata_r;

  wdcm_clk_monitor #(
    .LIMIT_CYC (CM_LIMIT_CYC)
  ) u_clk_monitor (
    .clk_i         (clk_i),
    .rst_i         (int_rst),
    .osc_tick_i    (osc_tick_i),
    .stop_clocks_i (stop_clocks_i),
    .enable_i      (cm_on),
    .bus_tick_o    (bus_tick),
    .fail_o        (cm_fail)
  );

  // select window counts bus cycles after any reset
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      win_cnt_r <= 7'h00;
    end else if (bus_tick && win_open) begin
      win_cnt_r <= win_cnt_r + 7'h01;
    end
  end

  assign win_open = (win_cnt_r < `WDCM_SEL_WINDOW);

  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      tsel_r <= `WDCM_TSEL_RST;
    end else if (wr_go && be0 && avs_address_i == `WDCM_OFS_OPTION && win_open) begin
      tsel_r <= wbyte[`WDCM_OPT_TSEL_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      cc_en_r <= 1'b0;
    end else if (wr_go && be0 && avs_address_i == `WDCM_OFS_OPTION) begin
      cc_en_r <= wbyte[`WDCM_OPT_CCEN_BIT];
    end
  end

  // lock can only be set; software has no way back short of a reset
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      cc_lock_r <= 1'b0;
    end else if (wr_go && be0 && avs_address_i == `WDCM_OFS_OPTION
                 && wbyte[`WDCM_OPT_LOCK_BIT]) begin
      cc_lock_r <= 1'b1;
    end
  end

  assign cm_on = cc_en_r | cc_lock_r;

  wdcm_nv_cell #(
    .WIDTH (1)
  ) u_nv_cell (
    .clk_i   (clk_i),
    .we_i    (wr_go && be0 && avs_address_i == `WDCM_OFS_CONFIG),
    .wdata_i (wbyte[`WDCM_CFG_DIS_BIT]),
    .rdata_o (nv_dis)
  );

  assign wd_en = ~nv_dis;

  assign svc_wr   = wr_go && be0 && avs_address_i == `WDCM_OFS_SERVICE;
  // a service landing inside the reset pulse is dropped, the pulse wins
  assign svc_done = svc_wr && wbyte == `WDCM_SVC_FIRE && armed_r && !int_rst;
  assign bad_svc  = svc_wr && wbyte == `WDCM_SVC_FIRE && !armed_r;

  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      armed_r <= 1'b0;
    end else if (svc_wr && wbyte == `WDCM_SVC_ARM) begin
      armed_r <= 1'b1;
    end else if (svc_wr && wbyte == `WDCM_SVC_FIRE) begin
      armed_r <= 1'b0;
    end
  end

  always_comb begin
    case (tsel_r)
      2'h0:    wd_limit = 24'(TO0_TICKS);
      2'h1:    wd_limit = 24'(TO1_TICKS);
      2'h2:    wd_limit = 24'(TO2_TICKS);
      default: wd_limit = 24'(TO3_TICKS);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (int_rst || svc_done || !wd_en) begin
      wd_cnt_r <= 24'h00_0000;
    end else if (bus_tick) begin
      wd_cnt_r <= wd_cnt_r + 24'h00_0001;
    end
  end

  assign wd_fail = wd_en && bus_tick && !svc_done && !int_rst
                   && (wd_cnt_r == wd_limit - 24'h00_0001);
  assign fail = (wd_fail | cm_fail) && rst_state_r == WDCM_RS_IDLE;

  // pulse timed in crystal cycles, since the bus clock may be dead
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_state_r <= WDCM_RS_IDLE;
      pulse_cnt_r <= 4'h0;
    end else begin
      case (rst_state_r)
        WDCM_RS_IDLE: begin
          if (fail) begin
            rst_state_r <= WDCM_RS_PULSE;
            pulse_cnt_r <= 4'(RST_CYC - 1);
          end
        end
        WDCM_RS_PULSE: begin
          if (pulse_cnt_r == 4'h0) begin
            rst_state_r <= WDCM_RS_IDLE;
          end else begin
            pulse_cnt_r <= pulse_cnt_r - 4'h1;
          end
        end
        default: rst_state_r <= WDCM_RS_IDLE;
      endcase
    end
  end

  assign reset_line_o    = 1'b0;
  assign reset_line_oe_o = (rst_state_r == WDCM_RS_PULSE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= WDCM_CAUSE_EXT;
    end else if (fail) begin
      cause_r <= wd_fail ? WDCM_CAUSE_WD : WDCM_CAUSE_CM;
    end
  end

  assign vector_sel_o = cause_r;

  assign ev[`WDCM_EV_WD]  = fail & wd_fail;
  assign ev[`WDCM_EV_CM]  = fail & ~wd_fail;
  assign ev[`WDCM_EV_BAD] = bad_svc;

  // a new event beats a clear landing in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= `WDCM_EV_W'(0);
    end else begin
      status_r <= (status_r & ~((wr_go && be0 && avs_address_i == `WDCM_OFS_CLEAR)
                  ? wbyte[`WDCM_EV_W-1:0] : `WDCM_EV_W'(0))) | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_r <= `WDCM_EV_W'(0);
    end else if (wr_go && be0 && avs_address_i == `WDCM_OFS_ENABLE) begin
      irq_en_r <= wbyte[`WDCM_EV_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & irq_en_r);
    end
  end

  assign irq_o = irq_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wd_timeout_reset: assert property (
    wd_fail && rst_state_r == WDCM_RS_IDLE |=> reset_line_oe_o)
    else $error("watchdog expiry did not pull reset");
  a_tsel_window: assert property (
    !win_open && !int_rst |=> $stable(tsel_r))
    else $error("select bits changed after window");
  a_disable_stops: assert property (
    nv_dis |=> wd_cnt_r == 24'h00_0000)
    else $error("watchdog counting while disabled");
  a_nv_survives: assert property (
    int_rst && !(wr_go && avs_address_i == `WDCM_OFS_CONFIG) |=> $stable(nv_dis))
    else $error("disable bit lost on reset");
  a_service_restart: assert property (
    svc_done |=> wd_cnt_r == 24'h00_0000 ##1 !reset_line_oe_o)
    else $error("service did not restart period");
  a_lock_holds: assert property (
    cc_lock_r && !int_rst |=> cm_on)
    else $error("locked monitor was disabled");
  a_cm_reset: assert property (
    cm_fail && rst_state_r == WDCM_RS_IDLE |=> reset_line_oe_o && cause_r != WDCM_CAUSE_EXT)
    else $error("clock failure did not reset");
  a_pulse_short: assert property (
    $rose(reset_line_oe_o) |-> ##11 reset_line_oe_o ##1 !reset_line_oe_o)
    else $error("reset pulse length wrong");
  a_cause_kept: assert property (
    wd_fail && rst_state_r == WDCM_RS_IDLE |=> vector_sel_o == WDCM_CAUSE_WD)
    else $error("watchdog cause not recorded");
  a_bad_service: assert property (
    bad_svc && !fail && !int_rst && wd_en |=> wd_cnt_r >= $past(wd_cnt_r))
    else $error("unarmed AAh serviced watchdog");
  a_reset_clears: assert property (
    int_rst |=> wd_cnt_r == 24'h00_0000)
    else $error("counter survived reset");

  c_service: cover property (svc_done);
  c_wd_reset: cover property (wd_fail && rst_state_r == WDCM_RS_IDLE);
  c_cm_reset: cover property (cm_fail && rst_state_r == WDCM_RS_IDLE);
  c_irq: cover property ($rose(irq_o));
  // a lone AAh must be seen while the count runs
  c_bad_service: cover property (bad_svc && wd_en);
endmodule // wdcm_top
`default_nettype wire

/* dv/wdcm_sw_model.sv */
// software-side avalon master model issuing single register accesses
`timescale 1ns/100ps
`default_nettype none
module wdcm_sw_model (
  input  wire logic        clk_i,             // block clock
  input  wire logic        rst_i,             // reset, sync, high
  input  wire logic        go_i,              // start one access
  input  wire logic        rd_i,              // 1 read, 0 write
  input  wire logic [7:0]  addr_i,            // register offset
  input  wire logic [31:0] wdata_i,           // write value
  output logic             done_o,            // access complete pulse
  output logic      [31:0] rdata_o,           // captured read data
  output logic      [7:0]  avs_address_o,     // to slave
  output logic             avs_read_o,        // to slave
  output logic             avs_write_o,       // to slave
  output logic      [31:0] avs_writedata_o,   // to slave
  output logic      [3:0]  avs_byteenable_o,  // to slave
  input  wire logic [31:0] avs_readdata_i,    // from slave
  input  wire logic        avs_waitrequest_i  // from slave
);
  // held until waitrequest is seen low; on release address and write data are inverted so stale values never match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_read_o       <= 1'b0;
      avs_write_o      <= 1'b0;
      avs_address_o    <= 8'h00;
      avs_writedata_o  <= 32'h0000_0000;
      avs_byteenable_o <= 4'h0;
      done_o           <= 1'b0;
      rdata_o          <= 32'h0000_0000;
    end else begin
      done_o <= 1'b0;
      if (go_i && !avs_read_o && !avs_write_o) begin
        avs_read_o       <= rd_i;
        avs_write_o      <= !rd_i;
        avs_address_o    <= addr_i;
        avs_writedata_o  <= wdata_i;
        avs_byteenable_o <= 4'hf;
      end else if ((avs_read_o || avs_write_o) && !avs_waitrequest_i) begin
        avs_read_o       <= 1'b0;
        avs_write_o      <= 1'b0;
        avs_address_o    <= ~avs_address_o;
        avs_writedata_o  <= ~avs_writedata_o;
        avs_byteenable_o <= 4'h0;
        rdata_o          <= avs_readdata_i;
        done_o           <= 1'b1;
      end
    end
  end
endmodule // wdcm_sw_model
`default_nettype wire

/* dv/tb_watchdog_and_clock_monitor.sv */
// self-checking bench for the watchdog and clock monitor block
`timescale 1ns/100ps
`default_nettype none
`include "wdcm_params.svh"
module tb_watchdog_and_clock_monitor;
  import wdcm_pkg::*;
  logic clk_i = 0, rst_i = 1, go = 0, rd = 0, osc_tick_i = 1, stop_clocks_i = 0;
  logic [7:0]  addr = 0, av_addr;
  logic [31:0] wdata = 0, rdata, av_wd, av_rdata;
  logic [3:0]  av_be;
  logic        done, av_rd, av_wr, av_wait, rl, rl_oe, irq, oe_q = 0;
  wdcm_cause_type vsel;
  int n_fail = 0, total_checks = 0, osc_mode = 0, rises = 0, r0, w, e;
  int unsigned to_t[4] = '{40, 80, 120, 160};
  realtime t_fall, t_rise, t0, t_prev;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    osc_tick_i <= (osc_mode == 0) ? 1'b1 : (osc_mode == 1) ? 1'($urandom % 2) : 1'b0;
    oe_q <= rl_oe;
    if (rl_oe === 1'b1 && oe_q !== 1'b1) rises <= rises + 1;
  end

  wdcm_sw_model sw_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .rd_i(rd), .addr_i(addr),
    .wdata_i(wdata), .done_o(done), .rdata_o(rdata), .avs_address_o(av_addr),
    .avs_read_o(av_rd), .avs_write_o(av_wr), .avs_writedata_o(av_wd),
    .avs_byteenable_o(av_be), .avs_readdata_i(av_rdata), .avs_waitrequest_i(av_wait));
  // short periods keep the run small; expectations scale from to_t
  wdcm_top #(.TO0_TICKS(40), .TO1_TICKS(80), .TO2_TICKS(120), .TO3_TICKS(160),
    .CM_LIMIT_CYC(40)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(av_addr),
    .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wd),
    .avs_byteenable_i(av_be), .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
    .osc_tick_i(osc_tick_i), .stop_clocks_i(stop_clocks_i), .reset_line_o(rl),
    .reset_line_oe_o(rl_oe), .vector_sel_o(vsel), .irq_o(irq));

  // bus ticks to crystal clocks, the bus clock being a quarter rate
  function automatic int exp_clks(input int unsigned ticks);
    return int'(ticks * `WDCM_BUS_DIV);
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic fail_now();
    n_fail++;
    $display("MISMATCH t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    conclude();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_i);
    go <= 1'b1;
    rd <= r;
    addr <= a;
    wdata <= wd;
    @(posedge clk_i);
    go <= 1'b0;
    while (done !== 1'b1 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    if (done !== 1'b1) fail_now();
  endtask
  task automatic wait_oe(input int bound);
    int k;
    k = 0;
    while (rl_oe !== 1'b1 && k < bound) begin
      @(negedge clk_i);
      k++;
    end
    if (rl_oe !== 1'b1) fail_now();
    chk(32'(rl), 32'h0000_0000);
    t_prev = t_fall;
    t_rise = $realtime;
    w = 0;
    while (rl_oe === 1'b1 && w < 50) begin
      @(negedge clk_i);
      w++;
    end
    t_fall = $realtime;
  endtask

  initial begin
    void'($urandom(32'h3c2f));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1, `WDCM_OFS_CAUSE, 0); chk(rdata, 32'h0000_0004);
    bus(1, `WDCM_OFS_CONFIG, 0); chk(rdata & 32'h1, 32'h1);
    bus(1, `WDCM_OFS_OPTION, 0); chk(rdata & 32'hf, 32'h0);
    bus(1, 8'h1c, 0); chk(rdata, 32'h0000_0000);
    $display("test reset values done");
    bus(0, `WDCM_OFS_CONFIG, 0);
    bus(0, `WDCM_OFS_ENABLE, 7);
    wait_oe(1000);
    for (int s = 0; s < 4; s++) begin
      bus(0, `WDCM_OFS_OPTION, s);
      wait_oe(2000);
      e = exp_clks(to_t[s]);
      chk_rng(int'((t_rise - t_prev) / 8), e - 8, e + 8);
      chk(32'(w), 32'h0000_000c);
      bus(1, `WDCM_OFS_CAUSE, 0); chk(rdata & 32'h3, 32'h1);
      chk(32'(vsel), 32'(WDCM_CAUSE_WD));
    end
    $display("test timeout periods done");
    bus(0, `WDCM_OFS_CONFIG, 1);
    bus(0, `WDCM_OFS_OPTION, 1);
    bus(1, `WDCM_OFS_OPTION, 0); chk(rdata & 32'h3, 32'h1);
    bus(1, `WDCM_OFS_CONFIG, 0); chk(rdata & 32'h1, 32'h1);
    repeat (300) @(posedge clk_i);
    bus(0, `WDCM_OFS_OPTION, 2);
    bus(1, `WDCM_OFS_OPTION, 0); chk(rdata & 32'h3, 32'h1);
    bus(0, `WDCM_OFS_ENABLE, 0);
    repeat (2) @(negedge clk_i); chk(irq, 1'b0);
    bus(0, `WDCM_OFS_ENABLE, 7);
    repeat (2) @(negedge clk_i); chk(irq, 1'b1);
    bus(0, `WDCM_OFS_CLEAR, 7);
    bus(1, `WDCM_OFS_STATUS, 0); chk(rdata & 32'h7, 32'h0);
    repeat (2) @(negedge clk_i); chk(irq, 1'b0);
    $display("test select window and interrupt done");
    // service gaps random but each loop stays inside the 320 clock period
    bus(0, `WDCM_OFS_CONFIG, 0);
    r0 = rises;
    for (int i = 0; i < 8; i++) begin
      bus(0, `WDCM_OFS_SERVICE, `WDCM_SVC_ARM);
      repeat ($urandom % 40) @(posedge clk_i);
      if (i == 3) bus(0, `WDCM_OFS_SERVICE, 8'h12);
      bus(0, `WDCM_OFS_SERVICE, `WDCM_SVC_FIRE);
      t0 = $realtime;
      repeat ($urandom % 150) @(posedge clk_i);
    end
    chk(32'(rises), 32'(r0));
    bus(0, `WDCM_OFS_SERVICE, `WDCM_SVC_FIRE);
    bus(1, `WDCM_OFS_STATUS, 0); chk(rdata & 32'h4, 32'h4);
    wait_oe(1000);
    e = exp_clks(to_t[1]);
    chk_rng(int'((t_rise - t0) / 8), e - 8, e + 8);
    $display("test service pattern done");
    bus(0, `WDCM_OFS_CONFIG, 1);
    bus(0, `WDCM_OFS_CLEAR, 7);
    bus(0, `WDCM_OFS_OPTION, 4);
    osc_mode <= 1;
    r0 = rises;
    repeat (500) @(posedge clk_i);
    chk(32'(rises), 32'(r0));
    bus(0, `WDCM_OFS_OPTION, 0);
    osc_mode <= 2;
    repeat (100) @(posedge clk_i);
    chk(32'(rises), 32'(r0));
    bus(0, `WDCM_OFS_OPTION, 4);
    wait_oe(200);
    osc_mode <= 0;
    bus(1, `WDCM_OFS_CAUSE, 0); chk(rdata & 32'h3, 32'h2);
    bus(0, `WDCM_OFS_OPTION, 4);
    @(posedge clk_i);
    stop_clocks_i <= 1'b1;
    wait_oe(200);
    @(posedge clk_i);
    stop_clocks_i <= 1'b0;
    chk(32'(vsel), 32'(WDCM_CAUSE_CM));
    bus(0, `WDCM_OFS_OPTION, 12);
    bus(0, `WDCM_OFS_OPTION, 0);
    bus(1, `WDCM_OFS_OPTION, 0); chk(rdata & 32'hc, 32'h8);
    osc_mode <= 2;
    wait_oe(200);
    osc_mode <= 0;
    chk(32'(vsel), 32'(WDCM_CAUSE_CM));
    bus(1, `WDCM_OFS_OPTION, 0); chk(rdata & 32'hc, 32'h0);
    $display("test clock monitor done");
    conclude();
  end
endmodule // tb_watchdog_and_clock_monitor
`default_nettype wire
